// ==== inc/qwp_pkg.sv ====
// Package for the quad wiper five-wire port: widths, reset values, codes.
// Assumes a single system clock on both ends of the link.
package qwp_pkg;
   localparam int          QWP_WIPER_W    = 6;
   localparam int          QWP_NUM_POTS   = 4;
   localparam int          QWP_WORD_W     = 8;
   localparam int          QWP_SEL_POS    = 6;
   localparam logic [5:0]  QWP_MID_SCALE  = 6'h20;
   localparam logic [5:0]  QWP_HIGH_END   = 6'h3F;
   localparam logic [5:0]  QWP_LOW_END    = 6'h00;
   localparam logic [3:0]  QWP_LAST_BIT   = 4'h7;
   localparam logic [3:0]  QWP_BIT_RESET  = 4'h0;
   // Link clock half period in system clock cycles (200 ns at 50 ns).
   localparam time         QWP_LINK_HALF_NS = 200;
   localparam time         QWP_CLK_NS       = 50;
   localparam logic [7:0]  QWP_HALF_CYC     =
      8'(QWP_LINK_HALF_NS / QWP_CLK_NS);
   typedef enum logic [1:0] {QWP_IDLE, QWP_LOW, QWP_HIGH, QWP_END} qwp_hst_t;
endpackage : qwp_pkg

// ==== inc/qwp_if.sv ====
// Interface joining the controller end and the device end of the port.
// The link wires are plain one-way pins; no tristate is needed.
`timescale 1ns/1ns
interface qwp_if;
   logic window;
   logic dirRead;
   logic sclk;
   logic sdin;
   logic cascadeOut;
   modport device (input window, input dirRead, input sclk, input sdin,
                   output cascadeOut);
   modport host   (output window, output dirRead, output sclk,
                   output sdin, input cascadeOut);
endinterface : qwp_if

// ==== hw/qwp_sync.sv ====
// Two flip-flop synchroniser for a pin from outside the clock domain.
// Assumes clk is the system clock; the output lags the pin by two edges.
`timescale 1ns/1ns
module qwp_sync (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic pin,
   output logic      synced
);
   logic meta_r;
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         meta_r <= 1'b0;
         synced <= 1'b0;
      end else begin
         meta_r <= pin;
         synced <= meta_r;
      end
   end
endmodule : qwp_sync

// ==== hw/qwp_device.sv ====
// Device end: four wiper registers loaded and read over the five-wire port.
// Assumes link pins are asynchronous to clk and sampled by synchronisers.
// Each link edge is seen three clk cycles late, so the link clock must stay
// well below a quarter of clk; the controller end runs at one eighth.
// Summary of operation
// - Four independent six-bit wiper registers.
// - Wipers reset to mid-scale 32.
// - 63 is high end, 0 low end.
// - Port active only while choice pin low.
// - Choice pin high disables five-wire functions.
// - Words move MSB first, eight bits each.
// - Top two bits select, low six position.
// - Window rising edge starts; active while high.
// - Controller settles direction before opening window.
// - Direction captured at window open.
// - Write: sample input on rising clock.
// - Load wiper at eighth clock falling edge.
// - One to four words, any order.
// - Window falling edge ends transaction.
// - Cascade output suppressed during writes.
// - Window low passes input to cascade.
// - Read: shift out after falling clock.
// - Read order pot 0 to 3, MSB first.
`timescale 1ns/1ns
module qwp_device
   import qwp_pkg::*;
#(
   parameter int NUM_POTS = QWP_NUM_POTS
) (
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   qwp_if.device                       link,
   input  wire logic                   interfaceChoicePin,
   output logic [NUM_POTS*QWP_WIPER_W-1:0] wiperPos,
   output logic [NUM_POTS-1:0]          wiperAtHighEnd,
   output logic [NUM_POTS-1:0]          wiperAtLowEnd
);
   logic       winS;
   logic       dirS;
   logic       clkS;
   logic       dinS;
   logic       choiceS;

   logic       winD_r;
   logic       clkD_r;
   logic       active_r;
   logic       isRead_r;

   logic [7:0] shift_r;
   logic [3:0] bitCnt_r;
   logic [3:0] rdCnt_r;
   logic       loadPend_r;

   logic [1:0] readPot_r;
   logic [7:0] readSh_r;
   logic       dout_r;
   logic [QWP_WIPER_W-1:0] wiper_r [NUM_POTS];

   qwp_sync uWin (.clk(clk), .reset_n(reset_n), .pin(link.window),
                  .synced(winS));
   qwp_sync uDir (.clk(clk), .reset_n(reset_n), .pin(link.dirRead),
                  .synced(dirS));
   qwp_sync uClk (.clk(clk), .reset_n(reset_n), .pin(link.sclk),
                  .synced(clkS));
   qwp_sync uDin (.clk(clk), .reset_n(reset_n), .pin(link.sdin),
                  .synced(dinS));
   qwp_sync uPs  (.clk(clk), .reset_n(reset_n), .pin(interfaceChoicePin),
                  .synced(choiceS));

   // Edge detectors start at the idle low level of both pins, so no false
   // edge follows reset.
   wire winRise = winS & ~winD_r;
   wire clkRise = clkS & ~clkD_r;
   wire clkFall = ~clkS & clkD_r;
   // Port on only with choice pin low.
   wire portOn  = ~choiceS;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         winD_r <= 1'b0;
         clkD_r <= 1'b0;
      end else begin
         winD_r <= winS;
         clkD_r <= clkS;
      end
   end

   // Transaction start and hold.
   // A window that rises while the choice pin is high is never started.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         active_r <= 1'b0;
         isRead_r <= 1'b0;
      end else if (choiceS || !winS) begin
         active_r <= 1'b0;
      end else if (winRise) begin
         active_r <= 1'b1;
         isRead_r <= dirS;
      end
   end

   // Write bits on rising clock.
   // A full word raises loadPend_r and waits for the falling edge that loads.
   always_ff @(posedge clk) begin
      if (!reset_n || !active_r || choiceS) begin
         shift_r    <= 8'h00;
         bitCnt_r   <= QWP_BIT_RESET;
         loadPend_r <= 1'b0;
      end else if (!isRead_r && clkRise) begin
         shift_r  <= {shift_r[6:0], dinS};
         if (bitCnt_r == QWP_LAST_BIT) begin
            bitCnt_r   <= QWP_BIT_RESET;
            loadPend_r <= 1'b1;
         end else begin
            bitCnt_r <= bitCnt_r + 4'h1;
         end
      end else if (clkFall) begin
         loadPend_r <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         for (int i = 0; i < NUM_POTS; i++) begin
            wiper_r[i] <= QWP_MID_SCALE;
         end
      end else if (active_r && loadPend_r && clkFall && portOn) begin
         // Each word picks its own pot.
         wiper_r[shift_r[7:QWP_SEL_POS]] <= shift_r[QWP_WIPER_W-1:0];
      end
   end

   // Read data shifts after falling clock.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         readPot_r <= 2'h0;
         readSh_r  <= 8'h00;
      end else if (winRise && dirS && !choiceS) begin
         // Start with pot 0, MSB first.
         readPot_r <= 2'h1;
         readSh_r  <= {2'h0, wiper_r[0]};
      end else if (active_r && isRead_r && clkFall) begin
         if (rdCnt_r == QWP_LAST_BIT) begin
            // Next word queued; after pot 3 the index wraps back to pot 0.
            readPot_r <= readPot_r + 2'h1;
            readSh_r  <= {readPot_r, wiper_r[readPot_r]};
         end else begin
            readSh_r <= {readSh_r[6:0], 1'b0};
         end
      end
   end

   // Read bits are counted on falling edges, apart from the write counter,
   // because a read never clocks the write shift register.
   always_ff @(posedge clk) begin
      if (!reset_n || !active_r) begin
         rdCnt_r <= QWP_BIT_RESET;
      end else if (isRead_r && clkFall) begin
         rdCnt_r <= (rdCnt_r == QWP_LAST_BIT) ? QWP_BIT_RESET
                                              : rdCnt_r + 4'h1;
      end
   end

   // Cascade output: idle pass-through, read data, or quiet during writes.
   // It is registered so the pin never glitches between the choices.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         dout_r <= 1'b0;
      end else if (choiceS) begin
         dout_r <= 1'b0;
      end else if (!winS) begin
         dout_r <= dinS;
      end else if (winRise && dirS) begin
         // First bit before first clock.
         // The pot 0 word begins with its zero index bits, so the first
         // bit is known before the shift register has loaded.
         dout_r <= 1'b0;
      end else if (active_r && isRead_r) begin
         dout_r <= readSh_r[7];
      end else begin
         dout_r <= 1'b0;
      end
   end
   assign link.cascadeOut = dout_r;

   // Four six-bit positions.
   // Flags are decoded from the registers so they follow every load at once.
   always_comb begin
      for (int i = 0; i < NUM_POTS; i++) begin
         wiperPos[i*QWP_WIPER_W +: QWP_WIPER_W] = wiper_r[i];
         wiperAtHighEnd[i] = (wiper_r[i] == QWP_HIGH_END);
         wiperAtLowEnd[i]  = (wiper_r[i] == QWP_LOW_END);
      end
   end
endmodule : qwp_device

// ==== hw/qwp_host.sv ====
// Controller end: sends up to four write words or reads all four words.
// Assumes a single-cycle start pulse and stable inputs while busy.
`timescale 1ns/1ns
module qwp_host
   import qwp_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset_n,
   qwp_if.host              link,
   input  wire logic        start,
   input  wire logic        doRead,
   input  wire logic [2:0]  numWords,
   input  wire logic [31:0] wrData,
   output logic             busy,
   output logic [31:0]      rdData,
   output logic             done
);
   qwp_hst_t   st_r;
   logic [7:0] div_r;
   logic [5:0] bitIdx_r;
   logic [5:0] total_r;
   logic       win_r;
   logic       dir_r;
   logic       sclk_r;
   logic       sdin_r;
   logic       doneP_r;
   logic [31:0] rd_r;
   logic       cascS;

   qwp_sync uCas (.clk(clk), .reset_n(reset_n), .pin(link.cascadeOut),
                  .synced(cascS));

   wire tick = (div_r == QWP_HALF_CYC - 8'h01);

   always_ff @(posedge clk) begin
      if (!reset_n || st_r == QWP_IDLE || tick) begin
         div_r <= 8'h00;
      end else begin
         div_r <= div_r + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_r     <= QWP_IDLE;
         win_r    <= 1'b0;
         dir_r    <= 1'b0;
         sclk_r   <= 1'b0;
         sdin_r   <= 1'b0;
         bitIdx_r <= 6'h00;
         total_r  <= 6'h00;
         doneP_r  <= 1'b0;
         rd_r     <= 32'h0000_0000;
      end else begin
         doneP_r <= 1'b0;
         case (st_r)
            QWP_IDLE: begin
               if (start) begin
                  dir_r    <= doRead;
                  total_r  <= doRead ? 6'h20 : {numWords, 3'h0};
                  bitIdx_r <= 6'h00;
                  sdin_r   <= wrData[31];
                  st_r     <= QWP_END;
               end
            end
            QWP_END: begin
               if (tick && !win_r) begin
                  win_r <= 1'b1;
                  st_r  <= QWP_LOW;
               end else if (tick) begin
                  win_r   <= 1'b0;
                  doneP_r <= 1'b1;
                  st_r    <= QWP_IDLE;
               end
            end
            QWP_LOW: begin
               if (tick) begin
                  sclk_r <= 1'b1;
                  st_r   <= QWP_HIGH;
               end
            end
            default: begin
               if (tick) begin
                  // Sample just before the falling edge: the
                  // device answer crosses one two-flop synchroniser each way and
                  // is not settled by the rising edge.
                  if (dir_r) begin
                     rd_r <= {rd_r[30:0], cascS};
                  end
                  sclk_r   <= 1'b0;
                  bitIdx_r <= bitIdx_r + 6'h01;
                  sdin_r   <= wrData[5'(6'd30 - bitIdx_r)];
                  st_r     <= (bitIdx_r + 6'h01 == total_r) ? QWP_END
                                                             : QWP_LOW;
               end
            end
         endcase
      end
   end

   assign link.window  = win_r;
   assign link.dirRead = dir_r;
   assign link.sclk    = sclk_r;
   assign link.sdin    = sdin_r;
   assign busy   = (st_r != QWP_IDLE);
   assign done   = doneP_r;
   assign rdData = rd_r;
endmodule : qwp_host

// ==== verif/qwp_checker.sv ====
// Link checker for the five-wire port between both ends.
// Assumes plain link signals sampled on the system clock.
`timescale 1ns/1ns
module qwp_checker (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic window,
   input wire logic dirRead,
   input wire logic sclk,
   input wire logic sdin,
   input wire logic cascadeOut
);
   logic [5:0] edgeCnt_r;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   always_ff @(posedge clk) begin
      if (!reset_n || !window)
         edgeCnt_r <= 6'h00;
      else if ($rose(sclk))
         edgeCnt_r <= edgeCnt_r + 6'h01;
   end
   write_quiet_a: assert property (
      (window && !dirRead)[*5] |-> !cascadeOut)
      else $error("cascade active in write");
   pass_through_a: assert property (
      (!window && $stable(sdin))[*6] |-> cascadeOut == sdin)
      else $error("cascade not passing input");
   dir_hold_a: assert property (
      window && $past(window) |-> $stable(dirRead))
      else $error("direction moved in window");
   dir_setup_a: assert property (
      $rose(window) |-> $past(dirRead, 3) == dirRead)
      else $error("direction not settled");
   clk_idle_a: assert property (!window |-> !sclk)
      else $error("link clock outside window");
   half_period_a: assert property (
      $rose(sclk) |-> sclk[*4] ##1 !sclk)
      else $error("link clock high time wrong");
   whole_bytes_a: assert property (
      $fell(window) |-> edgeCnt_r[2:0] == 3'h0 && edgeCnt_r != 6'h00
      && edgeCnt_r <= 6'h20) else $error("bad bit count");
   read_stable_a: assert property (
      window && dirRead && sclk && $past(sclk) |-> $stable(cascadeOut))
      else $error("read bit moved while clock high");
   cover property ($rose(window) && !dirRead);
   cover property ($rose(window) && dirRead);
   cover property ($fell(window) && edgeCnt_r == 6'h20);
endmodule : qwp_checker

// ==== verif/quad_wiper_five_wire_port_tb.sv ====
// Bench: controller end drives the device end; a second device is
// bit-banged. Assumes the designer's link timing of four cycles a half.
`timescale 1ns/1ns
module quad_wiper_five_wire_port_tb;
   import qwp_pkg::*;
   logic        clk;
   logic        reset_n;
   logic        start;
   logic        doRead;
   logic [2:0]  numWords;
   logic [31:0] wrData;
   logic [31:0] rdData;
   logic        done;
   logic        busy;
   logic        choiceB;
   logic [23:0] pos;
   logic [23:0] posB;
   logic [3:0]  atHi;
   logic [3:0]  atLo;
   int          n_fail;
   int          cmp_count;
   int          cycles;
   qwp_if link ();
   qwp_if linkB ();
   qwp_host qwp_host_i (.clk(clk), .reset_n(reset_n), .link(link),
      .start(start), .doRead(doRead), .numWords(numWords),
      .wrData(wrData), .busy(busy), .rdData(rdData), .done(done));
   qwp_device qwp_device_i (.clk(clk), .reset_n(reset_n), .link(link),
      .interfaceChoicePin(1'b0), .wiperPos(pos), .wiperAtHighEnd(atHi),
      .wiperAtLowEnd(atLo));
   qwp_device qwp_device_b_i (.clk(clk), .reset_n(reset_n), .link(linkB),
      .interfaceChoicePin(choiceB), .wiperPos(posB), .wiperAtHighEnd(),
      .wiperAtLowEnd());
   qwp_checker qwp_checker_i (.clk(clk), .reset_n(reset_n),
      .window(link.window), .dirRead(link.dirRead), .sclk(link.sclk),
      .sdin(link.sdin), .cascadeOut(link.cascadeOut));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic xfer(input logic rd, input logic [2:0] n,
                       input logic [31:0] d);
      int k;
      doRead = rd;
      numWords = n;
      wrData = d;
      start = 1'b1;
      cyc(1);
      start = 1'b0;
      chk({31'h0, busy}, 32'h1);
      k = 0;
      while (done !== 1'b1 && k < 600) begin
         cyc(1);
         k++;
      end
      chk({31'h0, done}, 32'h1);
      chk({31'h0, busy}, 32'h0);
      cyc(6);
   endtask : xfer
   // Direction flips mid-window on purpose; the device must ignore it.
   task automatic bang(input logic [7:0] w, input int nb);
      linkB.window = 1'b1;
      for (int i = 0; i < nb; i++) begin
         linkB.sdin = w[7-i];
         if (i == 3)
            linkB.dirRead = 1'b1;
         cyc(4);
         linkB.sclk = 1'b1;
         cyc(4);
         linkB.sclk = 1'b0;
      end
      cyc(4);
      linkB.window = 1'b0;
      linkB.dirRead = 1'b0;
      cyc(8);
   endtask : bang
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         n_fail++;
         summarize();
      end
   end
   initial begin
      reset_n = 1'b0;
      start = 1'b0;
      doRead = 1'b0;
      numWords = 3'h1;
      wrData = 32'h0;
      choiceB = 1'b1;
      linkB.window = 1'b0;
      linkB.dirRead = 1'b0;
      linkB.sclk = 1'b0;
      linkB.sdin = 1'b0;
      cyc(5);
      reset_n = 1'b1;
      cyc(2);
      chk({8'h0, pos}, {8'h0, {4{QWP_MID_SCALE}}});
      chk({24'h0, atHi, atLo}, 32'h0);
      xfer(1'b0, 3'h4, 32'hFF00956A);
      chk({8'h0, pos}, {8'h0, 6'h3F, 6'h15, 6'h2A, 6'h00});
      chk({24'h0, atHi, atLo}, 32'h81);
      xfer(1'b0, 3'h1, 32'h45000000);
      chk({8'h0, pos}, {8'h0, 6'h3F, 6'h15, 6'h05, 6'h00});
      xfer(1'b1, 3'h4, 32'h0);
      chk(rdData, 32'h004595FF);
      chk({8'h0, pos}, {8'h0, 6'h3F, 6'h15, 6'h05, 6'h00});
      bang(8'hC1, 8);
      chk({8'h0, posB}, {8'h0, {4{QWP_MID_SCALE}}});
      linkB.sdin = 1'b1;
      cyc(4);
      chk({31'h0, linkB.cascadeOut}, 32'h0);
      choiceB = 1'b0;
      cyc(4);
      chk({31'h0, linkB.cascadeOut}, 32'h1);
      linkB.sdin = 1'b0;
      cyc(4);
      chk({31'h0, linkB.cascadeOut}, 32'h0);
      bang(8'h81, 5);
      chk({8'h0, posB}, {8'h0, {4{QWP_MID_SCALE}}});
      bang(8'h81, 8);
      chk({8'h0, posB}, {8'h0, 6'h20, 6'h01, 6'h20, 6'h20});
      summarize();
   end
endmodule : quad_wiper_five_wire_port_tb
